// ===== hdl/dsic_consts.svh
`ifndef DSIC_CONSTS_SVH
`define DSIC_CONSTS_SVH

// ==========================================================
// Frame layout
`define DSIC_FRAME_BITS      24
`define DSIC_CNT_W           5
`define DSIC_DATA_W          16
`define DSIC_MODE_HI_POS     17
`define DSIC_MODE_LO_POS     16
`define DSIC_DATA_RESET      16'h0000

// ==========================================================
// Register map (byte addresses)
`define DSIC_ADDR_W          8
`define DSIC_OFF_CTRL        8'h00
`define DSIC_OFF_STATUS      8'h04
`define DSIC_OFF_CODE        8'h08
`define DSIC_OFF_LAST        8'h0C
`define DSIC_OFF_COUNT       8'h10

// ==========================================================
// Control and status fields
`define DSIC_CTRL_LOWSUP_BIT 0
`define DSIC_CTRL_LINKEN_BIT 1
`define DSIC_CTRL_RESET      2'h2
`define DSIC_ST_ABORT_BIT    4
`define DSIC_ST_DONE_BIT     5

// ==========================================================
// Timing
`define DSIC_PCLK_NS         20
`define DSIC_EXIT_5V_NS      2500
`define DSIC_EXIT_3V_NS      5000
`define DSIC_EXIT_5V_CYC     (`DSIC_EXIT_5V_NS / `DSIC_PCLK_NS)
`define DSIC_EXIT_3V_CYC     (`DSIC_EXIT_3V_NS / `DSIC_PCLK_NS)
`define DSIC_EXIT_CNT_W      9

`endif

// ===== hdl/dsic_pkg.sv
`default_nettype none

package dsic_pkg;

   // ==========================================================
   // Operating modes
   typedef enum logic [1:0] {
      DSIC_MODE_NORMAL = 2'h0,
      DSIC_MODE_PD_1K  = 2'h1,
      DSIC_MODE_PD_100K = 2'h2,
      DSIC_MODE_PD_HIZ = 2'h3
   } dsic_mode_t;

   // ==========================================================
   // Output stage states
   typedef enum logic [1:0] {
      DSIC_OUT_ON   = 2'h0,
      DSIC_OUT_DOWN = 2'h1,
      DSIC_OUT_WAKE = 2'h3
   } dsic_out_state_t;

endpackage

`default_nettype wire

// ===== hdl/dsic_sync.sv
`default_nettype none

module dsic_sync #(
   parameter int           W       = 3,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Pins
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);

   // ==========================================================
   // Two flops per bit
   generate
      for (genvar i = 0; i < W; i++) begin : g_bit
         logic meta_q;
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_q      <= RST_VAL[i];
               sync_out[i] <= RST_VAL[i];
            end else begin
               meta_q      <= async_in[i];
               sync_out[i] <= meta_q;
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ===== hdl/dsic_frame_rx.sv
`include "dsic_consts.svh"
`default_nettype none

module dsic_frame_rx (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // Synchronised link
   input  wire logic                        frame_sel_n,
   input  wire logic                        sclk,
   input  wire logic                        sdin,
   // Frame results
   output logic                             frame_active,
   output logic                             frame_done,
   output logic                             frame_abort,
   output logic [`DSIC_FRAME_BITS-1:0]      frame_word
);

   logic                        sclk_prev_q;
   logic                        fs_prev_q;
   logic [`DSIC_FRAME_BITS-1:0] shift_q;
   logic [`DSIC_CNT_W-1:0]      cnt_q;
   logic                        fall;
   logic                        full;

   assign fall = sclk_prev_q & ~sclk;
   assign full = (cnt_q == `DSIC_CNT_W'(`DSIC_FRAME_BITS));

   // ==========================================================
   // Edge history
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_prev_q <= 1'b0;
         fs_prev_q   <= 1'b1;
      end else begin
         sclk_prev_q <= sclk;
         fs_prev_q   <= frame_sel_n;
      end
   end

   // ==========================================================
   // Shifting and counting
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q      <= '0;
         cnt_q        <= '0;
         frame_done   <= 1'b0;
         frame_abort  <= 1'b0;
         frame_word   <= '0;
         frame_active <= 1'b0;
      end else begin
         frame_done   <= 1'b0;
         frame_abort  <= 1'b0;
         frame_active <= ~frame_sel_n;
         if (frame_sel_n) begin
            shift_q     <= '0;
            cnt_q       <= '0;
            frame_abort <= ~fs_prev_q & ~full;
         end else if (fall && !full) begin
            shift_q <= {shift_q[`DSIC_FRAME_BITS-2:0], sdin};
            cnt_q   <= cnt_q + `DSIC_CNT_W'(1);
            if (cnt_q == `DSIC_CNT_W'(`DSIC_FRAME_BITS - 1)) begin
               frame_done <= 1'b1;
               frame_word <= {shift_q[`DSIC_FRAME_BITS-2:0], sdin};
            end
         end
      end
   end

endmodule

`default_nettype wire

// ===== hdl/dsic_top.sv
`include "dsic_consts.svh"
`default_nettype none

module dsic_top (
   // Clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [`DSIC_ADDR_W-1:0]     paddr,
   input  wire logic [31:0]                 pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Serial link pins
   input  wire logic                        frame_sel_n,
   input  wire logic                        sclk,
   input  wire logic                        sdin,
   // Converter core
   output logic [`DSIC_DATA_W-1:0]          dac_code,
   output dsic_pkg::dsic_mode_t             op_mode,
   output logic                             out_valid
);
   import dsic_pkg::*;

   // ==========================================================
   // Declarations
   logic [2:0]                  pins_s;
   logic                        rx_active;
   logic                        rx_done;
   logic                        rx_abort;
   logic [`DSIC_FRAME_BITS-1:0] rx_word;

   logic [1:0]                  ctrl_q;
   logic [`DSIC_DATA_W-1:0]     code_q;
   dsic_mode_t                  mode_q;
   dsic_mode_t                  new_mode;
   logic [`DSIC_FRAME_BITS-1:0] last_q;
   logic                        abort_seen_q;
   logic                        done_seen_q;
   logic [15:0]                 done_cnt_q;
   logic [15:0]                 abort_cnt_q;
   dsic_out_state_t             out_state_q;
   logic [`DSIC_EXIT_CNT_W-1:0] wake_cnt_q;
   logic                        valid_q;

   logic                        take;
   logic                        wr_en;
   logic                        rd_en;
   logic                        frame_ok;
   logic                        frame_bad;
   logic                        hit;
   logic [31:0]                 rdata;
   logic [`DSIC_EXIT_CNT_W-1:0] wake_len;

   // ==========================================================
   // Pin synchronisers
   dsic_sync #(
      .W       (3),
      .RST_VAL (3'h4)
   ) u_sync (
      .clk      (pclk),
      .rst_n    (presetn),
      .async_in ({frame_sel_n, sclk, sdin}),
      .sync_out (pins_s)
   );

   // ==========================================================
   // Frame receiver
   dsic_frame_rx u_rx (
      .clk          (pclk),
      .rst_n        (presetn),
      .frame_sel_n  (pins_s[2]),
      .sclk         (pins_s[1]),
      .sdin         (pins_s[0]),
      .frame_active (rx_active),
      .frame_done   (rx_done),
      .frame_abort  (rx_abort),
      .frame_word   (rx_word)
   );

   assign frame_ok  = rx_done & ctrl_q[`DSIC_CTRL_LINKEN_BIT];
   assign frame_bad = rx_abort & ctrl_q[`DSIC_CTRL_LINKEN_BIT];
   assign new_mode  = dsic_mode_t'({rx_word[`DSIC_MODE_HI_POS],
                                    rx_word[`DSIC_MODE_LO_POS]});

   // ==========================================================
   // APB decode
   assign take  = psel & penable & pready;
   assign wr_en = take & pwrite & ~pslverr;
   assign rd_en = psel & penable & ~pready;

   always_comb begin
      hit   = 1'b1;
      rdata = '0;
      case (paddr)
         `DSIC_OFF_CTRL: begin
            rdata[1:0] = ctrl_q;
         end
         `DSIC_OFF_STATUS: begin
            rdata[0]                  = rx_active;
            rdata[1]                  = valid_q;
            rdata[3:2]                = mode_q;
            rdata[`DSIC_ST_ABORT_BIT] = abort_seen_q;
            rdata[`DSIC_ST_DONE_BIT]  = done_seen_q;
            rdata[7:6]                = out_state_q;
         end
         `DSIC_OFF_CODE: begin
            rdata[`DSIC_DATA_W-1:0] = code_q;
         end
         `DSIC_OFF_LAST: begin
            rdata[`DSIC_FRAME_BITS-1:0] = last_q;
         end
         `DSIC_OFF_COUNT: begin
            rdata = {abort_cnt_q, done_cnt_q};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // APB response, one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= rd_en;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= rd_en & ~hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else begin
         prdata <= (rd_en && !pwrite) ? rdata : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `DSIC_CTRL_RESET;
      end else if (wr_en && paddr == `DSIC_OFF_CTRL) begin
         ctrl_q <= pwdata[1:0];
      end
   end

   // ==========================================================
   // Data register and mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_q <= `DSIC_DATA_RESET;
      end else if (frame_ok) begin
         code_q <= rx_word[`DSIC_DATA_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= DSIC_MODE_NORMAL;
      end else if (frame_ok) begin
         mode_q <= new_mode;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= '0;
      end else if (frame_ok) begin
         last_q <= rx_word;
      end
   end

   // ==========================================================
   // Abort flag, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_seen_q <= 1'b0;
      end else if (frame_bad) begin
         abort_seen_q <= 1'b1;
      end else if (wr_en && paddr == `DSIC_OFF_STATUS
                   && pwdata[`DSIC_ST_ABORT_BIT]) begin
         abort_seen_q <= 1'b0;
      end
   end

   // ==========================================================
   // Done flag, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_seen_q <= 1'b0;
      end else if (frame_ok) begin
         done_seen_q <= 1'b1;
      end else if (wr_en && paddr == `DSIC_OFF_STATUS
                   && pwdata[`DSIC_ST_DONE_BIT]) begin
         done_seen_q <= 1'b0;
      end
   end

   // ==========================================================
   // Completed frame counter, any write clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_cnt_q <= '0;
      end else if (wr_en && paddr == `DSIC_OFF_COUNT) begin
         done_cnt_q <= {15'h0000, frame_ok};
      end else begin
         done_cnt_q <= done_cnt_q + {15'h0000, frame_ok};
      end
   end

   // ==========================================================
   // Aborted frame counter, any write clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_cnt_q <= '0;
      end else if (wr_en && paddr == `DSIC_OFF_COUNT) begin
         abort_cnt_q <= {15'h0000, frame_bad};
      end else begin
         abort_cnt_q <= abort_cnt_q + {15'h0000, frame_bad};
      end
   end

   // ==========================================================
   // Output stage and wake-up delay
   assign wake_len = ctrl_q[`DSIC_CTRL_LOWSUP_BIT]
                   ? `DSIC_EXIT_CNT_W'(`DSIC_EXIT_3V_CYC)
                   : `DSIC_EXIT_CNT_W'(`DSIC_EXIT_5V_CYC);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_state_q <= DSIC_OUT_ON;
         wake_cnt_q  <= '0;
         valid_q     <= 1'b1;
      end else begin
         case (out_state_q)
            DSIC_OUT_ON: begin
               if (frame_ok && new_mode != DSIC_MODE_NORMAL) begin
                  out_state_q <= DSIC_OUT_DOWN;
                  valid_q     <= 1'b0;
               end
            end
            DSIC_OUT_DOWN: begin
               if (frame_ok && new_mode == DSIC_MODE_NORMAL) begin
                  out_state_q <= DSIC_OUT_WAKE;
                  wake_cnt_q  <= wake_len - `DSIC_EXIT_CNT_W'(1);
               end
            end
            DSIC_OUT_WAKE: begin
               if (frame_ok && new_mode != DSIC_MODE_NORMAL) begin
                  out_state_q <= DSIC_OUT_DOWN;
               end else if (frame_ok) begin
                  wake_cnt_q <= wake_len - `DSIC_EXIT_CNT_W'(1);
               end else if (wake_cnt_q == '0) begin
                  out_state_q <= DSIC_OUT_ON;
                  valid_q     <= 1'b1;
               end else begin
                  wake_cnt_q <= wake_cnt_q - `DSIC_EXIT_CNT_W'(1);
               end
            end
            default: begin
               out_state_q <= DSIC_OUT_DOWN;
               valid_q     <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Core outputs
   assign dac_code  = code_q;
   assign op_mode   = mode_q;
   assign out_valid = valid_q;

endmodule

`default_nettype wire

// ===== dv/dsic_host_model.sv
`default_nettype none

module dsic_host_model (
   // Clock
   input  wire logic pclk,
   // Serial link pins
   output var  logic frame_sel_n,
   output var  logic sclk,
   output var  logic sdin
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Idle levels
   initial begin
      frame_sel_n <= 1'b1;
      sclk        <= 1'b0;
      sdin        <= 1'b0;
   end

   // ==========================================================
   // Frame control
   task automatic start();
      @(posedge pclk);
      frame_sel_n <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask

   // Bits sent MSB first, changed on rise, sampled on fall, 160 ns period
   task automatic shift(input logic [23:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         sclk <= 1'b1;
         sdin <= w[23-i];
         repeat (4) @(posedge pclk);
         sclk <= 1'b0;
         repeat (4) @(posedge pclk);
      end
   endtask

   // Data line inverts two cycles before frame select is released
   task automatic stop();
      sdin <= ~sdin;
      repeat (2) @(posedge pclk);
      frame_sel_n <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask
endmodule

`default_nettype wire

// ===== dv/dsic_top_properties.sv
`include "dsic_consts.svh"
`default_nettype none

module dsic_top_properties (
   // Clock and reset
   input wire logic                    pclk,
   input wire logic                    presetn,
   // APB
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [`DSIC_ADDR_W-1:0] paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   // Link and core
   input wire logic                    frame_sel_n,
   input wire logic                    sclk,
   input wire logic                    sdin,
   input wire logic [`DSIC_DATA_W-1:0] dac_code,
   input wire dsic_pkg::dsic_mode_t    op_mode,
   input wire logic                    out_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   import dsic_pkg::*;

   logic [9:0] wake_q;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ==========================================================
   // Wake cycle counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wake_q <= 10'h0;
      else if (op_mode != DSIC_MODE_NORMAL || out_valid || $changed(dac_code))
         wake_q <= 10'h0;
      else
         wake_q <= wake_q + 10'h1;
   end

   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      !pready ##1 pready;
   endsequence

   // ==========================================================
   // Properties
   apb_wait_a: assert property (setup_s |=> answer_s)
      else $error("APB answer not after one wait state");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   slverr_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside answer");
   code_in_frame_a: assert property (
      ($changed(dac_code) || $changed(op_mode)) |-> !$past(frame_sel_n, 5))
      else $error("Core update outside a frame");
   code_idle_a: assert property (
      frame_sel_n [*8] |-> $stable(dac_code) && $stable(op_mode))
      else $error("Core changed with frame select high");
   pd_clears_valid_a: assert property (
      ($changed(op_mode) && op_mode != DSIC_MODE_NORMAL) |-> !out_valid)
      else $error("Output valid in power-down");
   valid_normal_a: assert property (out_valid |-> op_mode == DSIC_MODE_NORMAL)
      else $error("Output valid outside normal mode");
   wake_min_a: assert property ($rose(out_valid) |-> wake_q >= 10'h07C)
      else $error("Wake from power-down too short");
   wake_max_a: assert property (wake_q <= 10'h0FC)
      else $error("Wake from power-down too long");
endmodule

bind dsic_top dsic_top_properties u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .frame_sel_n(frame_sel_n), .sclk(sclk), .sdin(sdin), .dac_code(dac_code),
   .op_mode(op_mode), .out_valid(out_valid)
);

`default_nettype wire

// ===== dv/testbench.sv
`include "dsic_consts.svh"
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import dsic_pkg::*;

   // ==========================================================
   // Signals and instances
   logic                    pclk = 1'b0;
   logic                    presetn = 1'b0;
   logic                    psel = 1'b0;
   logic                    penable = 1'b0;
   logic                    pwrite = 1'b0;
   logic [`DSIC_ADDR_W-1:0] paddr = 8'h00;
   logic [31:0]             pwdata = 32'h0;
   logic [31:0]             prdata;
   logic [31:0]             rd;
   logic                    pready;
   logic                    pslverr;
   logic                    er;
   wire logic               frame_sel_n;
   wire logic               sclk;
   wire logic               sdin;
   logic [`DSIC_DATA_W-1:0] dac_code;
   dsic_mode_t              op_mode;
   logic                    out_valid;
   int                      errors = 0;
   int                      n_compared = 0;
   int                      cyc = 0;

   dsic_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_sel_n(frame_sel_n), .sclk(sclk), .sdin(sdin), .dac_code(dac_code),
      .op_mode(op_mode), .out_valid(out_valid)
   );
   dsic_host_model host (.pclk(pclk), .frame_sel_n(frame_sel_n), .sclk(sclk), .sdin(sdin));

   always #10 pclk = ~pclk;

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors = errors + 1;
         report_and_stop();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   task automatic send(input logic [1:0] m, input logic [15:0] c);
      host.start();
      host.shift({6'h2A, m, c}, 24);
      host.stop();
      tick(6);
   endtask

   task automatic expect_core(input logic [1:0] m, input logic [15:0] c);
      check({14'h0, op_mode, dac_code}, {14'h0, m, c});
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      expect_core(2'h0, 16'h0000);
      check({31'h0, out_valid}, 32'h1);
      apb(1'b0, `DSIC_OFF_CTRL, 32'h0);
      check(rd, 32'h2);
      apb(1'b0, `DSIC_OFF_STATUS, 32'h0);
      check(rd, 32'h2);
   endtask

   task automatic t_modes();
      logic [15:0] codes [4] = '{16'hFFFF, 16'h0001, 16'h8000, 16'h7FFE};
      for (int m = 0; m < 4; m++) begin
         send(2'(3 - m), codes[m]);
         expect_core(2'(3 - m), codes[m]);
         apb(1'b0, `DSIC_OFF_LAST, 32'h0);
         check(rd, {8'h0, 6'h2A, 2'(3 - m), codes[m]});
      end
   endtask

   task automatic wake(input logic [31:0] ctrl, input int lo, input int hi);
      int n;
      n = 0;
      apb(1'b1, `DSIC_OFF_CTRL, ctrl);
      send(2'h3, 16'h4321);
      check({31'h0, out_valid}, 32'h0);
      host.start();
      host.shift({6'h00, 2'h0, 16'h4321}, 24);
      while (out_valid !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      host.stop();
      check({31'h0, n >= lo && n <= hi}, 32'h1);
      check({16'h0, dac_code}, 32'h4321);
   endtask

   task automatic t_abort();
      apb(1'b1, `DSIC_OFF_COUNT, 32'h0);
      apb(1'b1, `DSIC_OFF_STATUS, 32'h30);
      host.start();
      host.shift(24'hFFFFFF, 23);
      host.stop();
      host.start();
      host.stop();
      tick(6);
      expect_core(2'h0, 16'h4321);
      send(2'h0, 16'h0F0F);
      expect_core(2'h0, 16'h0F0F);
      apb(1'b0, `DSIC_OFF_COUNT, 32'h0);
      check(rd, 32'h0002_0001);
      apb(1'b0, `DSIC_OFF_STATUS, 32'h0);
      check(rd & 32'h30, 32'h30);
   endtask

   task automatic t_extra();
      host.start();
      host.shift({6'h15, 2'h0, 16'hC3C3}, 24);
      host.shift(24'h5A5A5A, 24);
      host.stop();
      tick(6);
      expect_core(2'h0, 16'hC3C3);
   endtask

   task automatic t_bytes();
      logic [7:0] b [3] = '{8'hFC, 8'hA5, 8'h0F};
      host.start();
      foreach (b[i]) begin
         host.shift({b[i], 16'h0}, 8);
         tick(10);
      end
      host.stop();
      tick(6);
      expect_core(2'h0, 16'hA50F);
   endtask

   task automatic t_regs();
      apb(1'b0, 8'h14, 32'h0);
      check({31'h0, er}, 32'h1);
      check(rd, 32'h0);
      apb(1'b1, `DSIC_OFF_CODE, 32'hFFFF);
      apb(1'b0, `DSIC_OFF_CODE, 32'h0);
      check(rd, 32'hA50F);
      apb(1'b1, `DSIC_OFF_CTRL, 32'h0);
      send(2'h1, 16'h1111);
      expect_core(2'h0, 16'hA50F);
      apb(1'b1, `DSIC_OFF_CTRL, 32'h2);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      tick(3);
      presetn <= 1'b1;
      tick(2);
      t_reset();
      t_modes();
      wake(32'h2, 123, 129);
      wake(32'h3, 248, 254);
      t_abort();
      t_extra();
      t_bytes();
      t_regs();
      presetn <= 1'b0;
      tick(3);
      presetn <= 1'b1;
      tick(2);
      t_reset();
      report_and_stop();
   end
endmodule

`default_nettype wire
